// ===== core/lit_pkg.sv
// Constants, encodings and types shared by the long interval timekeeper.
// Assumes a byte-wide special function register port and a 32.768 kHz time base pin.
package lit_pkg;

  // Register addresses on the special function register port
  localparam logic [7:0] ADDR_CTRL = 8'ha1;
  localparam logic [7:0] ADDR_FRAC = 8'ha2;
  localparam logic [7:0] ADDR_SEC = 8'ha3;
  localparam logic [7:0] ADDR_MIN = 8'ha4;
  localparam logic [7:0] ADDR_HOUR = 8'ha5;
  localparam logic [7:0] ADDR_MATCH = 8'ha6;

  // Control register field positions
  localparam int CTRL_TK_EN = 0;
  localparam int CTRL_RUN_EN = 1;
  localparam int CTRL_FLAG = 2;
  localparam int CTRL_SINGLE = 3;
  localparam int CTRL_BASE_LO = 4;
  localparam int CTRL_BASE_HI = 5;
  localparam int CTRL_HOUR24 = 6;

  // Reset and read values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MATCH_RESET = 8'h00;
  localparam logic [7:0] TIME_RESET = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // Time base division down to the 1/128 second tick
  localparam int TB_HZ = 32768;
  localparam int TICK_HZ = 128;
  localparam int TB_DIV = TB_HZ / TICK_HZ;
  localparam int PRE_W = 8;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TB_DIV - 1);

  // Counting limits of the time registers
  localparam logic [7:0] FRAC_MAX = 8'h7f;
  localparam logic [7:0] SEC_MAX = 8'h3b;
  localparam logic [7:0] MIN_MAX = 8'h3b;
  localparam logic [7:0] HOUR24_MAX = 8'h17;

  // Time register write-enable indices
  localparam int TIDX_FRAC = 0;
  localparam int TIDX_SEC = 1;
  localparam int TIDX_MIN = 2;
  localparam int TIDX_HOUR = 3;
  localparam int TIME_REGS = 4;

  // Interrupt service entry reported with a wake request
  localparam logic [15:0] WAKE_VECTOR = 16'h0053;

  typedef enum logic [1:0] {
    LIT_BASE_FRAC = 2'h0,
    LIT_BASE_SEC = 2'h1,
    LIT_BASE_MIN = 2'h2,
    LIT_BASE_HOUR = 2'h3
  } lit_base_e;

  typedef enum logic [1:0] {
    LIT_IV_IDLE = 2'h1,
    LIT_IV_RUN = 2'h2
  } lit_iv_e;

endpackage : lit_pkg

// ===== core/lit_time_chain.sv
// Fraction, seconds, minutes and hours counters with their written-value shadows.
// Assumes tick is a one-cycle 1/128 second pulse from the same clock domain.
`timescale 1ns/1ps
`default_nettype none

module lit_time_chain (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Control
  input wire logic tick,
  input wire logic run,
  input wire logic hour_wrap_select,
  // Software writes
  input wire logic [lit_pkg::TIME_REGS-1:0] wr_en,
  input wire logic [7:0] wdata,
  // Time values and rollover pulses
  output logic [7:0] fraction_count,
  output logic [7:0] sec_count,
  output logic [7:0] min_count,
  output logic [7:0] hour_count,
  output logic sec_tick,
  output logic min_tick,
  output logic hour_tick
);

  typedef struct packed {
    logic [7:0] frac;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] sh_frac;
    logic [7:0] sh_sec;
    logic [7:0] sh_min;
    logic [7:0] sh_hour;
  } lit_chain_s;

  lit_chain_s s_q;
  lit_chain_s s_d;

  function automatic logic [7:0] lit_wrap_inc(input logic [7:0] v, input logic [7:0] max);
    lit_wrap_inc = (v >= max) ? 8'h00 : 8'(v + 8'h01);
  endfunction : lit_wrap_inc

  assign sec_tick = tick && (s_q.frac == lit_pkg::FRAC_MAX);
  assign min_tick = sec_tick && (s_q.sec == lit_pkg::SEC_MAX);
  assign hour_tick = min_tick && (s_q.min == lit_pkg::MIN_MAX);

  always_comb begin
    s_d = s_q;
    // Writes land only while stopped; a running chain would race them
    if (!run) begin
      if (wr_en[lit_pkg::TIDX_FRAC]) s_d.sh_frac = wdata;
      if (wr_en[lit_pkg::TIDX_SEC]) s_d.sh_sec = wdata;
      if (wr_en[lit_pkg::TIDX_MIN]) s_d.sh_min = wdata;
      if (wr_en[lit_pkg::TIDX_HOUR]) s_d.sh_hour = wdata;
      s_d.frac = s_d.sh_frac;
      s_d.sec = s_d.sh_sec;
      s_d.min = s_d.sh_min;
      s_d.hour = s_d.sh_hour;
    end else if (tick) begin
      s_d.frac = lit_wrap_inc(s_q.frac, lit_pkg::FRAC_MAX);
      if (sec_tick) s_d.sec = lit_wrap_inc(s_q.sec, lit_pkg::SEC_MAX);
      if (min_tick) s_d.min = lit_wrap_inc(s_q.min, lit_pkg::MIN_MAX);
      if (hour_tick) begin
        if (hour_wrap_select) begin
          s_d.hour = lit_wrap_inc(s_q.hour, lit_pkg::HOUR24_MAX);
        end else begin
          s_d.hour = 8'(s_q.hour + 8'h01);
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{default: lit_pkg::TIME_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  assign fraction_count = s_q.frac;
  assign sec_count = s_q.sec;
  assign min_count = s_q.min;
  assign hour_count = s_q.hour;

endmodule : lit_time_chain

`default_nettype wire

// ===== core/lit_timekeeper.sv
// Long interval timekeeper: time base prescaler, interval counter, control and register port.
// Assumes a byte-wide register port on mclk and a free-running 32.768 kHz time base pin.
//
// Functional notes
// - Count time from the 32.768 kHz base pin
// - Keep counting while the chip is powered down
// - Step interval counter on each count of the selected register
// - Bits 5:4 pick fraction, second, minute, hour
// - Match sets flag bit 2, requests interrupt
// - Match in power-down wakes core at 0053H
// - Single shot: timeout clears interval enable
// - Repeat mode: reload and keep counting
// - Interval counter runs only with bit 1
// - Time base passes only with bit 0
// - Stopping restores last written time values
// - Time registers writable only while stopped
// - Bit 6 picks 24 or 256 hours
// - Intervals from one tick to 256 hours
// - Fraction counts 0..127, carries into seconds
// - Seconds and minutes count 0..59 with carry
`timescale 1ns/1ps
`default_nettype none

module lit_timekeeper (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Time base pin
  input wire logic tb_xtal_in,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Core status
  input wire logic irq_enable,
  input wire logic power_down,
  // Events to the core
  output logic irq_req,
  output logic wake_req,
  output logic [15:0] wake_vector
);

  typedef struct packed {
    logic xtal_meta;
    logic xtal_sync;
    logic xtal_prev;
    logic [lit_pkg::PRE_W-1:0] prescale;
    logic timekeeping_enable;
    logic interval_run_enable;
    logic match_flag;
    logic single_shot_select;
    logic interval_base_select_lo;
    logic interval_base_select_hi;
    logic hour_wrap_select;
    logic [7:0] match_value_reg;
    logic [7:0] long_interval_counter;
    lit_pkg::lit_iv_e iv_state;
    logic [7:0] rdata;
    logic irq;
    logic wake;
    logic [15:0] vector;
  } lit_top_s;

  lit_top_s s_q;
  lit_top_s s_d;

  function automatic logic lit_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    lit_hit = (addr == reg_addr);
  endfunction : lit_hit

  // Time chain interface
  logic [lit_pkg::TIME_REGS-1:0] time_wr;
  logic [7:0] fraction_count;
  logic [7:0] sec_count;
  logic [7:0] min_count;
  logic [7:0] hour_count;
  logic sec_tick;
  logic min_tick;
  logic hour_tick;

  // Derived per-cycle terms
  logic xtal_rise;
  logic frac_tick;
  logic iv_tick;
  logic iv_run;
  logic [7:0] iv_next;
  logic timeout;
  logic ctrl_wr;
  logic [7:0] counter_control_reg;
  lit_pkg::lit_base_e base_sel;

  assign ctrl_wr = sfr_wr && lit_hit(sfr_addr, lit_pkg::ADDR_CTRL);
  assign time_wr[lit_pkg::TIDX_FRAC] = sfr_wr && lit_hit(sfr_addr, lit_pkg::ADDR_FRAC);
  assign time_wr[lit_pkg::TIDX_SEC] = sfr_wr && lit_hit(sfr_addr, lit_pkg::ADDR_SEC);
  assign time_wr[lit_pkg::TIDX_MIN] = sfr_wr && lit_hit(sfr_addr, lit_pkg::ADDR_MIN);
  assign time_wr[lit_pkg::TIDX_HOUR] = sfr_wr && lit_hit(sfr_addr, lit_pkg::ADDR_HOUR);

  // Only the synchronised copy feeds the edge detector
  assign xtal_rise = s_q.xtal_sync && !s_q.xtal_prev;
  assign frac_tick = s_q.timekeeping_enable && xtal_rise && (s_q.prescale == lit_pkg::PRE_LAST);

  assign base_sel = lit_pkg::lit_base_e'({s_q.interval_base_select_hi, s_q.interval_base_select_lo});

  always_comb begin
    unique case (base_sel)
      lit_pkg::LIT_BASE_FRAC: iv_tick = frac_tick;
      lit_pkg::LIT_BASE_SEC: iv_tick = sec_tick;
      lit_pkg::LIT_BASE_MIN: iv_tick = min_tick;
      lit_pkg::LIT_BASE_HOUR: iv_tick = hour_tick;
    endcase
  end

  assign iv_run = s_q.timekeeping_enable && s_q.interval_run_enable;
  assign iv_next = 8'(s_q.long_interval_counter + 8'h01);
  // A match value of zero therefore spans a full 256 ticks
  assign timeout = (s_q.iv_state == lit_pkg::LIT_IV_RUN) && iv_run && iv_tick
                   && (iv_next == s_q.match_value_reg);

  assign counter_control_reg = {1'b0, s_q.hour_wrap_select, s_q.interval_base_select_hi,
                                s_q.interval_base_select_lo, s_q.single_shot_select,
                                s_q.match_flag, s_q.interval_run_enable, s_q.timekeeping_enable};

  lit_time_chain u_chain (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(frac_tick),
    .run(s_q.timekeeping_enable),
    .hour_wrap_select(s_q.hour_wrap_select),
    .wr_en(time_wr),
    .wdata(sfr_wdata),
    .fraction_count(fraction_count),
    .sec_count(sec_count),
    .min_count(min_count),
    .hour_count(hour_count),
    .sec_tick(sec_tick),
    .min_tick(min_tick),
    .hour_tick(hour_tick)
  );

  always_comb begin
    s_d = s_q;
    s_d.xtal_meta = tb_xtal_in;
    s_d.xtal_sync = s_q.xtal_meta;
    s_d.xtal_prev = s_q.xtal_sync;

    // Prescaler cleared while stopped so restart begins a whole tick
    if (!s_q.timekeeping_enable) begin
      s_d.prescale = '0;
    end else if (xtal_rise) begin
      s_d.prescale = lit_pkg::PRE_W'(s_q.prescale + 1'b1);
    end

    // Control and match writes; power-down never gates any of this
    if (ctrl_wr) begin
      s_d.timekeeping_enable = sfr_wdata[lit_pkg::CTRL_TK_EN];
      s_d.interval_run_enable = sfr_wdata[lit_pkg::CTRL_RUN_EN];
      s_d.single_shot_select = sfr_wdata[lit_pkg::CTRL_SINGLE];
      s_d.interval_base_select_lo = sfr_wdata[lit_pkg::CTRL_BASE_LO];
      s_d.interval_base_select_hi = sfr_wdata[lit_pkg::CTRL_BASE_HI];
      s_d.hour_wrap_select = sfr_wdata[lit_pkg::CTRL_HOUR24];
      s_d.match_flag = s_q.match_flag && sfr_wdata[lit_pkg::CTRL_FLAG];
    end
    if (sfr_wr && lit_hit(sfr_addr, lit_pkg::ADDR_MATCH)) begin
      s_d.match_value_reg = sfr_wdata;
    end

    // Interval counter
    unique case (s_q.iv_state)
      lit_pkg::LIT_IV_IDLE: begin
        s_d.long_interval_counter = 8'h00;
        if (iv_run) s_d.iv_state = lit_pkg::LIT_IV_RUN;
      end
      lit_pkg::LIT_IV_RUN: begin
        if (!iv_run) begin
          s_d.long_interval_counter = 8'h00;
          s_d.iv_state = lit_pkg::LIT_IV_IDLE;
        end else if (timeout) begin
          s_d.long_interval_counter = 8'h00;
        end else if (iv_tick) begin
          s_d.long_interval_counter = iv_next;
        end
      end
      default: begin
        s_d.long_interval_counter = 8'h00;
        s_d.iv_state = lit_pkg::LIT_IV_IDLE;
      end
    endcase

    // A match in the same cycle as a clearing write still sets the flag
    if (timeout) begin
      s_d.match_flag = 1'b1;
      if (s_q.single_shot_select) s_d.interval_run_enable = 1'b0;
    end

    // Register reads answer one cycle after the strobe
    if (sfr_rd) begin
      unique case (sfr_addr)
        lit_pkg::ADDR_CTRL: s_d.rdata = counter_control_reg;
        lit_pkg::ADDR_FRAC: s_d.rdata = fraction_count;
        lit_pkg::ADDR_SEC: s_d.rdata = sec_count;
        lit_pkg::ADDR_MIN: s_d.rdata = min_count;
        lit_pkg::ADDR_HOUR: s_d.rdata = hour_count;
        lit_pkg::ADDR_MATCH: s_d.rdata = s_q.match_value_reg;
        default: s_d.rdata = lit_pkg::RD_UNMAPPED;
      endcase
    end

    s_d.irq = s_d.match_flag && irq_enable;
    s_d.wake = s_d.match_flag && irq_enable && power_down;
    s_d.vector = lit_pkg::WAKE_VECTOR;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.xtal_meta <= 1'b0;
      s_q.xtal_sync <= 1'b0;
      s_q.xtal_prev <= 1'b0;
      s_q.prescale <= '0;
      s_q.timekeeping_enable <= lit_pkg::CTRL_RESET[lit_pkg::CTRL_TK_EN];
      s_q.interval_run_enable <= lit_pkg::CTRL_RESET[lit_pkg::CTRL_RUN_EN];
      s_q.match_flag <= lit_pkg::CTRL_RESET[lit_pkg::CTRL_FLAG];
      s_q.single_shot_select <= lit_pkg::CTRL_RESET[lit_pkg::CTRL_SINGLE];
      s_q.interval_base_select_lo <= lit_pkg::CTRL_RESET[lit_pkg::CTRL_BASE_LO];
      s_q.interval_base_select_hi <= lit_pkg::CTRL_RESET[lit_pkg::CTRL_BASE_HI];
      s_q.hour_wrap_select <= lit_pkg::CTRL_RESET[lit_pkg::CTRL_HOUR24];
      s_q.match_value_reg <= lit_pkg::MATCH_RESET;
      s_q.long_interval_counter <= 8'h00;
      s_q.iv_state <= lit_pkg::LIT_IV_IDLE;
      s_q.rdata <= lit_pkg::RD_UNMAPPED;
      s_q.irq <= 1'b0;
      s_q.wake <= 1'b0;
      s_q.vector <= lit_pkg::WAKE_VECTOR;
    end else begin
      s_q <= s_d;
    end
  end

  assign sfr_rdata = s_q.rdata;
  assign irq_req = s_q.irq;
  assign wake_req = s_q.wake;
  assign wake_vector = s_q.vector;

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_match_hit;
    timeout;
  endsequence

  sequence s_single_end;
    !s_q.interval_run_enable ##1 (s_q.iv_state == lit_pkg::LIT_IV_IDLE && s_q.long_interval_counter == 8'h00);
  endsequence

  sequence s_quiet_stop;
    // Stopped one cycle ahead, so the restore from the shadows has already landed
    !s_q.timekeeping_enable
      ##1 (!s_q.timekeeping_enable && !ctrl_wr && time_wr == '0) ##1 !s_q.timekeeping_enable;
  endsequence

  AST_TICK_RATE: assert property (frac_tick |-> ##1 !frac_tick [*8])
    else $error("fraction ticks closer than the prescaler allows");

  AST_PD_COUNTS: assert property (frac_tick && power_down && fraction_count != lit_pkg::FRAC_MAX
                                  |=> fraction_count == 8'($past(fraction_count) + 8'h01))
    else $error("fraction did not advance during power-down");

  AST_FRAC_WRAP: assert property (frac_tick && fraction_count == lit_pkg::FRAC_MAX && sec_count != lit_pkg::SEC_MAX
                                  |=> fraction_count == 8'h00 && sec_count == 8'($past(sec_count) + 8'h01))
    else $error("fraction rollover did not carry into seconds");

  AST_HOUR24_WRAP: assert property (hour_tick && s_q.hour_wrap_select && hour_count == lit_pkg::HOUR24_MAX
                                    |=> hour_count == 8'h00)
    else $error("hour did not wrap after 23");

  AST_HOUR256_WRAP: assert property (hour_tick && !s_q.hour_wrap_select && hour_count == lit_pkg::HOUR24_MAX
                                     |=> hour_count == 8'h18)
    else $error("hour wrapped early in 256-hour mode");

  AST_STOPPED_FROZEN: assert property (s_quiet_stop |-> $stable(fraction_count) && $stable(hour_count)
                                       && s_q.long_interval_counter == 8'h00)
    else $error("time moved while the time base was stopped");

  AST_IV_STEP: assert property (s_q.iv_state == lit_pkg::LIT_IV_RUN && iv_run && iv_tick && !timeout
                                |=> s_q.long_interval_counter == 8'($past(s_q.long_interval_counter) + 8'h01))
    else $error("interval counter missed its selected tick");

  AST_BASE_SEC: assert property (base_sel == lit_pkg::LIT_BASE_SEC
                                 |-> iv_tick == (frac_tick && fraction_count == lit_pkg::FRAC_MAX))
    else $error("seconds base does not follow the fraction rollover");

  AST_MATCH_FLAG: assert property (s_match_hit |=> s_q.match_flag && (irq_req || !$past(irq_enable)))
    else $error("match did not raise the flag and interrupt");

  AST_FLAG_HOLD: assert property (s_q.match_flag && !(ctrl_wr && !sfr_wdata[lit_pkg::CTRL_FLAG])
                                  |=> s_q.match_flag)
    else $error("match flag dropped without a clearing write");

  AST_WAKE: assert property ((s_match_hit and (irq_enable && power_down))
                             |=> wake_req && wake_vector == lit_pkg::WAKE_VECTOR)
    else $error("match in power-down did not wake the core");

  AST_SINGLE_SHOT: assert property ((s_match_hit and (s_q.single_shot_select && !ctrl_wr)) |=> s_single_end)
    else $error("single shot did not stop the interval counter");

  AST_RELOAD: assert property ((s_match_hit and (!s_q.single_shot_select && !ctrl_wr))
                               |=> s_q.interval_run_enable && s_q.long_interval_counter == 8'h00)
    else $error("repeat mode did not reload the interval counter");

  AST_IV_DISABLED: assert property (!iv_run |=> s_q.long_interval_counter == 8'h00)
    else $error("interval counter held a count while disabled");

  AST_RUN_WRITE_IGNORED: assert property (time_wr[lit_pkg::TIDX_FRAC] && s_q.timekeeping_enable && !frac_tick
                                          |=> $stable(fraction_count))
    else $error("fraction register written while running");

endmodule : lit_timekeeper

`default_nettype wire

// ===== sim/lit_timekeeper_tb.sv
// Self-checking bench for the long interval timekeeper: register port, time chain and interval events.
// Assumes the core/ design files; mclk runs at 125 MHz and the time base pin toggles every 2 mclk.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, gt) \
  begin \
    comparisons++; \
    if ((gt) !== (ex)) begin \
      mismatches++; \
      $display("mismatch %s expected %h seen %h", nm, ex, gt); \
    end \
  end

module lit_timekeeper_tb;
  // 256 base edges, one every 4 mclk, make one 1/128 s tick
  localparam int TICK_CYC = 1024;

  logic mclk = 1'b0;
  logic rst_n;
  logic tb_xtal_in = 1'b0;
  logic [7:0] sfr_addr;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic irq_enable;
  logic power_down;
  logic irq_req;
  logic wake_req;
  logic [15:0] wake_vector;
  int mismatches = 0;
  int comparisons = 0;
  integer seed = 32'h760c;
  int cyc = 0;
  int t0 = 0;
  logic [1:0] xdiv = 2'h0;
  logic [7:0] tm [4];
  logic [7:0] wv [4];
  logic [7:0] c;
  logic [7:0] hrs [4];
  logic h24s [4];

  always #4 mclk = ~mclk;

  always @(posedge mclk) begin
    cyc <= cyc + 1;
  end

  // Time base runs free, unrelated to any register activity
  always @(negedge mclk) begin
    xdiv <= xdiv + 2'h1;
    if (xdiv[0]) begin
      tb_xtal_in <= ~tb_xtal_in;
    end
  end

  lit_timekeeper i_dut (
    .mclk(mclk),
    .rst_n(rst_n),
    .tb_xtal_in(tb_xtal_in),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .irq_enable(irq_enable),
    .power_down(power_down),
    .irq_req(irq_req),
    .wake_req(wake_req),
    .wake_vector(wake_vector)
  );

  function automatic logic [7:0] rnd(input int lim);
    return 8'($unsigned($random(seed)) % lim);
  endfunction : rnd

  // One tick of the reference time chain
  function automatic void step(input logic h24);
    if (tm[0] != 8'h7f) begin
      tm[0] = tm[0] + 8'h01;
    end else begin
      tm[0] = 8'h00;
      if (tm[1] != 8'h3b) begin
        tm[1] = tm[1] + 8'h01;
      end else begin
        tm[1] = 8'h00;
        if (tm[2] != 8'h3b) begin
          tm[2] = tm[2] + 8'h01;
        end else begin
          tm[2] = 8'h00;
          tm[3] = (h24 && tm[3] >= 8'h17) ? 8'h00 : tm[3] + 8'h01;
        end
      end
    end
  endfunction : step

  function automatic logic [7:0] ctrl_after(input logic [7:0] cv);
    return (cv | 8'h04) & ~(cv[3] ? 8'h02 : 8'h00);
  endfunction : ctrl_after

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge mclk);
    sfr_wr = 1'b0;
    @(negedge mclk);
  endtask : wr

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] ex, input string nm);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge mclk);
    sfr_rd = 1'b0;
    @(negedge mclk);
    `CHK(nm, ex, sfr_rdata)
  endtask : chk_rd

  task automatic go(input logic [7:0] cv);
    wr(lit_pkg::ADDR_CTRL, cv);
    t0 = cyc;
  endtask : go

  // Margin covers the synchroniser and the unknown base phase at enable
  task automatic wait_ticks(input int n);
    while (cyc < t0 + n * TICK_CYC + 40) @(negedge mclk);
  endtask : wait_ticks

  task automatic preload(input logic [7:0] f, input logic [7:0] s, input logic [7:0] m, input logic [7:0] h);
    wr(lit_pkg::ADDR_CTRL, 8'h00);
    wv = '{f, s, m, h};
    tm = wv;
    for (int i = 0; i < 4; i++) wr(8'(lit_pkg::ADDR_FRAC + i), wv[i]);
  endtask : preload

  task automatic chk_time();
    chk_rd(lit_pkg::ADDR_FRAC, tm[0], "fraction");
    chk_rd(lit_pkg::ADDR_SEC, tm[1], "seconds");
    chk_rd(lit_pkg::ADDR_MIN, tm[2], "minutes");
    chk_rd(lit_pkg::ADDR_HOUR, tm[3], "hours");
  endtask : chk_time

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  // About 25 ticks of traffic; about 58 ticks means a hang
  initial begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    end_of_test();
  end

  initial begin
    rst_n = 1'b0;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    irq_enable = 1'b0;
    power_down = 1'b0;
    hrs = '{8'h17, 8'hff, 8'h17, rnd(24)};
    h24s = '{1'b1, 1'b0, 1'b0, 1'b1};
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    `CHK("wake_vector", lit_pkg::WAKE_VECTOR, wake_vector)
    for (int a = 'ha0; a <= 'ha7; a++) chk_rd(8'(a), 8'h00, "reset read");
    wr(lit_pkg::ADDR_CTRL, 8'h84);
    chk_rd(lit_pkg::ADDR_CTRL, 8'h00, "reserved and flag");
    // Written time runs, refuses writes while running, comes back on stop
    preload(rnd(100), rnd(60), rnd(60), rnd(24));
    go(8'h01);
    wait_ticks(1);
    step(1'b0);
    chk_rd(lit_pkg::ADDR_FRAC, tm[0], "running fraction");
    wr(lit_pkg::ADDR_FRAC, 8'h55);
    chk_rd(lit_pkg::ADDR_FRAC, tm[0], "write while running");
    wr(lit_pkg::ADDR_CTRL, 8'h00);
    for (int i = 0; i < 4; i++) chk_rd(8'(lit_pkg::ADDR_FRAC + i), wv[i], "restored");
    // Carries through every unit, both hour wraps
    for (int k = 0; k < 4; k++) begin
      preload(8'h7e, 8'h3b, 8'h3b, hrs[k]);
      go({1'b0, h24s[k], 6'h01});
      wait_ticks(2);
      step(h24s[k]);
      step(h24s[k]);
      chk_time();
    end
    // Each timebase with a single interval and its events
    irq_enable = 1'b1;
    for (int b = 0; b < 4; b++) begin
      power_down = (b == 3);
      preload(8'h7e, (b >= 2) ? 8'h3b : 8'h00, (b == 3) ? 8'h3b : 8'h00, 8'h00);
      wr(lit_pkg::ADDR_MATCH, (b == 0) ? 8'h02 : 8'h01);
      c = {2'b00, 2'(b), 4'hb};
      go(c);
      wait_ticks(1);
      chk_rd(lit_pkg::ADDR_CTRL, c, "before timeout");
      `CHK("irq before", 1'b0, irq_req)
      wait_ticks(2);
      chk_rd(lit_pkg::ADDR_CTRL, ctrl_after(c), "single timeout");
      `CHK("irq", 1'b1, irq_req)
      `CHK("wake", 1'(b == 3), wake_req)
    end
    // Repeat mode, masked request, flag hold and clear
    irq_enable = 1'b0;
    power_down = 1'b0;
    preload(8'h00, 8'h00, 8'h00, 8'h00);
    wr(lit_pkg::ADDR_MATCH, 8'h02);
    go(8'h03);
    wait_ticks(2);
    chk_rd(lit_pkg::ADDR_CTRL, 8'h07, "repeat timeout");
    `CHK("irq masked", 1'b0, irq_req)
    irq_enable = 1'b1;
    repeat (3) @(negedge mclk);
    `CHK("irq unmasked", 1'b1, irq_req)
    wait_ticks(3);
    chk_rd(lit_pkg::ADDR_CTRL, 8'h07, "flag held");
    wr(lit_pkg::ADDR_CTRL, 8'h03);
    chk_rd(lit_pkg::ADDR_CTRL, 8'h03, "flag cleared");
    wait_ticks(4);
    chk_rd(lit_pkg::ADDR_CTRL, 8'h07, "second interval");
    // Interval counter held while its enable is low
    preload(8'h00, 8'h00, 8'h00, 8'h00);
    wr(lit_pkg::ADDR_MATCH, 8'h01);
    go(8'h01);
    wait_ticks(3);
    chk_rd(lit_pkg::ADDR_CTRL, 8'h01, "interval off");
    end_of_test();
  end
endmodule : lit_timekeeper_tb

`default_nettype wire
